/* File: common/sac_pkg.sv */
// Package of constants and carriers for the SAR conversion control block
// Functional notes
// - Finished code lands in a high-byte and a low-byte result register.
// - Repeat count one gives an unsigned 10-bit code, zero to full scale.
// - Justify 000 right-aligns the code, 100 left-aligns it (0xFFC0 full scale).
// - Result bits not holding the formatted code read as zero.
// - Repeat above one presents the sum, updated after the series' last conversion.
// - Repeat count selects 4, 8, 16, 32 or 64 samples, unsigned sum.
// - A 16-bit accumulator sums results without processor help.
// - Justify may shift the accumulated sum right by one, two or three.
// - Conversion clock divides system clock, or low-power oscillator in burst.
// - Start-mode field picks software, one of four timers, or pin edge.
// - Start-mode value 100 selects the external start pin.
// - Busy reads one throughout a conversion, zero once complete.
// - Busy falling at a series' last conversion sets the done flag; result valid while flag is one.
// - Second and third timers use low overflow in 8-bit, high in 16-bit.
// - Tracking bit zero, burst off: track always except while converting.
// - Tracking bit one: three conversion clocks of tracking after each start.
// - Low-power tracking with pin trigger: track while pin low, convert at rise.
// - Tracking can be shut down during standby or sleep.
// - Burst runs repeat-count conversions per start; else one start each.
package sac_pkg;
  localparam logic [2:0] SM_SOFT   = 3'h0;
  localparam logic [2:0] SM_TMR0   = 3'h1;
  localparam logic [2:0] SM_TMR2   = 3'h2;
  localparam logic [2:0] SM_TMR3   = 3'h3;
  localparam logic [2:0] SM_EXT    = 3'h4;
  localparam logic [2:0] SM_TMRX   = 3'h5;
  localparam int         CODE_W    = 10;
  localparam int         ACC_W     = 16;
  localparam logic [3:0] TRACK_CLKS = 4'h3;
  localparam logic [3:0] CONV_CLKS  = 4'ha;
  localparam logic [2:0] JUST_LEFT  = 3'h4;
  localparam int         LEFT_SHIFT = 6;
  localparam logic [2:0] REP_1  = 3'h0;
  localparam logic [2:0] REP_4  = 3'h1;
  localparam logic [2:0] REP_8  = 3'h2;
  localparam logic [2:0] REP_16 = 3'h3;
  localparam logic [2:0] REP_32 = 3'h4;
  localparam logic [2:0] REP_64 = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV  = 2'b10
  } sac_state_e;

  // Software-owned configuration fields
  typedef struct packed {
    logic [2:0] start_mode_select;
    logic       tracking_mode_bit;
    logic       burst_enable_bit;
    logic [4:0] conv_clock_divider;
    logic [2:0] repeat_count_select;
    logic [2:0] justify_shift_select;
  } sac_cfg_s;

  // Timer overflow strobes and width modes
  typedef struct packed {
    logic tmr0_ovf;
    logic tmr2_lo_ovf;
    logic tmr2_hi_ovf;
    logic tmr2_16bit;
    logic tmr3_lo_ovf;
    logic tmr3_hi_ovf;
    logic tmr3_16bit;
    logic tmrx_ovf;
  } sac_tmr_s;
endpackage

/* File: dv/sac_ctrl_tb.sv */
// Self-checking bench for the SAR conversion control block
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl_tb;
  logic              i_clk, i_sys_rst, i_sw_start, i_done_clear, i_standby, go;
  logic              pin, lpo, busy, done, trk, cnv;
  logic [1:0]        wide;
  logic [2:0]        fire;
  logic [9:0]        code, smp;
  logic [7:0]        hi, lo;
  logic [7:0]        port_skip_reg;
  logic [15:0]       sum;
  sac_pkg::sac_cfg_s cfg;
  sac_pkg::sac_tmr_s tmr;
  int                miscompares, check_count, seed, n, tn;
  sac_far far (.i_clk, .i_sys_rst, .i_go(go), .i_fire(fire), .i_wide(wide),
    .i_pin_free(port_skip_reg[6]),
    .i_code(code), .o_tmr(tmr), .o_pin(pin), .o_lpo(lpo), .o_code(smp));
  sac_ctrl dut (.i_clk, .i_sys_rst, .i_cfg(cfg), .i_tmr(tmr), .i_sw_start,
    .i_external_start_pin(pin), .i_lpo_clk(lpo), .i_standby, .i_sample_code(smp),
    .i_done_clear, .o_result_high_byte(hi), .o_result_low_byte(lo),
    .o_conversion_busy_bit(busy), .o_conversion_done_flag(done), .o_track(trk),
    .o_convert(cnv));
  // System clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic end_sim();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compare one value, report at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait on busy (0), done (1) or convert (2); tn counts track cycles
  task automatic wt(input logic [1:0] sel, input logic lvl);
    n = 0;
    while ((sel == 2'h0 ? busy : sel == 2'h1 ? done : cnv) !== lvl) begin
      tn += int'(trk === 1'b1);
      @(negedge i_clk);
      n++;
      if (n > 3000) begin
        miscompares++;
        end_sim();
      end
    end
  endtask
  // One start from a source; clearing done with it saves a cycle per case
  task automatic kick(input logic [2:0] f);
    @(negedge i_clk);
    {go, fire, i_done_clear} = {1'b1, f, 1'b1};
    i_sw_start = f == 3'h0;
    @(negedge i_clk);
    {go, i_sw_start, i_done_clear} = '0;
  endtask
  // Expected register pair from a sum and the justify field
  function automatic logic [15:0] fmt(input logic [15:0] s, input logic [2:0] j);
    return (j == sac_pkg::JUST_LEFT) ? s << sac_pkg::LEFT_SHIFT : s >> j[1:0];
  endfunction
  initial begin
    {i_sw_start, i_done_clear, i_standby, go, fire, wide, code, cfg} = '0;
    {miscompares, check_count, tn} = '0;
    seed = 75;
    port_skip_reg = 8'h40;
    i_sys_rst = 1'b1;
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    chk({busy, done, trk, cnv, hi, lo[3:0]}, 16'h2000);
    // Every source in both timer widths, random codes, both alignments
    for (int p = 0; p < 2; p++) begin
      wide = {2{p[0]}};
      for (int m = 0; m < 6; m++) begin
        cfg.start_mode_select = 3'(m);
        cfg.justify_shift_select = m[0] ? sac_pkg::JUST_LEFT : 3'h0;
        code = m == 1 ? 10'h3ff : 10'($random(seed));
        kick(3'(m));
        wt(2'h0, 1'b1);
        chk(16'(n > 6), 16'(m == 2 || m == 3));
        wt(2'h1, 1'b1);
        chk({hi, lo}, fmt({6'h0, code}, cfg.justify_shift_select));
        chk(16'({busy, trk, cnv}), 16'h2);
      end
    end
    // Series without burst; a second start while busy must be dropped
    cfg.start_mode_select = 3'h0;
    for (int r = 1; r < 4; r++) begin
      cfg.repeat_count_select = 3'(r);
      cfg.justify_shift_select = 3'(r - 1);
      sum = '0;
      for (int k = 0; k < (2 << r); k++) begin
        code = 10'($random(seed));
        sum = sum + 16'(code);
        kick(3'h0);
        wt(2'h0, 1'b1);
        kick(3'h0);
        wt(2'h0, 1'b0);
        if (k < (2 << r) - 1) chk(16'(done), 16'h0);
      end
      wt(2'h1, 1'b1);
      chk({hi, lo}, fmt(sum, cfg.justify_shift_select));
    end
    // Low-power tracking ahead of each conversion, two divider settings
    cfg.repeat_count_select = 3'h0;
    cfg.justify_shift_select = 3'h0;
    cfg.tracking_mode_bit = 1'b1;
    for (int d = 0; d < 3; d += 2) begin
      cfg.conv_clock_divider = 5'(d);
      kick(3'h0);
      wt(2'h0, 1'b1);
      tn = 0;
      wt(2'h2, 1'b1);
      chk(16'(tn >= 2 * d + 3 && tn <= 4 * d + 3), 16'h1);
      wt(2'h1, 1'b1);
    end
    // Standby shuts tracking off
    cfg.tracking_mode_bit = 1'b0;
    cfg.conv_clock_divider = 5'h0;
    i_standby = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(16'(trk), 16'h0);
    i_standby = 1'b0;
    // Pin trigger in low-power tracking: track while low, convert on rise
    cfg.start_mode_select = 3'h4;
    cfg.tracking_mode_bit = 1'b1;
    repeat (3) @(negedge i_clk);
    chk(16'(trk), 16'h1);
    kick(3'h4);
    wt(2'h0, 1'b1);
    chk(16'({trk, cnv}), 16'h1);
    wt(2'h1, 1'b1);
    // Unassigned start mode: a software start must not begin anything
    cfg.start_mode_select = 3'h6;
    kick(3'h0);
    chk(16'(busy), 16'h0);
    // Burst: one start runs all 64 conversions off the oscillator
    cfg.start_mode_select = 3'h0;
    cfg.tracking_mode_bit = 1'b0;
    cfg.burst_enable_bit = 1'b1;
    cfg.repeat_count_select = sac_pkg::REP_64;
    code = 10'h3ff;
    for (int j = 0; j < 4; j += 3) begin
      cfg.justify_shift_select = 3'(j);
      kick(3'h0);
      wt(2'h1, 1'b1);
      chk({hi, lo}, j != 0 ? 16'h1ff8 : 16'hffc0);
    end
    end_sim();
  end
endmodule // sac_ctrl_tb
`default_nettype wire

/* File: dv/sac_far.sv */
// Far-side model: timers, start pin, analog input code, low-power oscillator
`timescale 1ns/1ns
`default_nettype none
module sac_far (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_go,
  input  wire logic [2:0]   i_fire,
  input  wire logic [1:0]   i_wide,
  input  wire logic         i_pin_free,
  input  wire logic [9:0]   i_code,
  output var sac_pkg::sac_tmr_s o_tmr,
  output logic              o_pin,
  output logic              o_lpo,
  output logic [9:0]        o_code
);
  logic [3:0] dly_r;
  logic [2:0] src_r, s;
  logic       e;
  // Mux hands the selected input level straight on
  assign o_code = i_code;
  assign s = i_go ? i_fire : src_r;
  assign e = i_go || dly_r == 4'h1;
  // Oscillator runs free, unrelated in phase to the system clock
  initial begin
    o_lpo = 1'b0;
    forever #13 o_lpo = ~o_lpo;
  end
  // Timers 2 and 3 first raise the byte overflow that must not count
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {o_tmr, o_pin, dly_r, src_r} <= '0;
    end else begin
      o_tmr <= '0;
      o_tmr.tmr2_16bit <= i_wide[0];
      o_tmr.tmr3_16bit <= i_wide[1];
      o_tmr.tmr0_ovf <= i_go && s == 3'h1;
      o_tmr.tmrx_ovf <= i_go && s == 3'h5;
      o_tmr.tmr2_lo_ovf <= e && s == 3'h2 && i_go == i_wide[0];
      o_tmr.tmr2_hi_ovf <= e && s == 3'h2 && i_go != i_wide[0];
      o_tmr.tmr3_lo_ovf <= e && s == 3'h3 && i_go == i_wide[1];
      o_tmr.tmr3_hi_ovf <= e && s == 3'h3 && i_go != i_wide[1];
      src_r <= s;
      dly_r <= i_go ? 4'h9 : dly_r - 4'(dly_r != 4'h0);
      // Pin reaches the converter only when the crossbar skips it
      o_pin <= i_pin_free && ((i_go && s == 3'h4) || (o_pin && dly_r != 4'h1));
    end
  end
endmodule // sac_far
`default_nettype wire

/* File: rtl/sac_ctrl.sv */
// SAR converter start, track, convert, accumulate and format control
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire sac_pkg::sac_cfg_s i_cfg,
  input  wire sac_pkg::sac_tmr_s i_tmr,
  input  wire logic              i_sw_start,
  input  wire logic              i_external_start_pin,
  input  wire logic              i_lpo_clk,
  input  wire logic              i_standby,
  input  wire logic [9:0]        i_sample_code,
  input  wire logic              i_done_clear,
  output logic [7:0]             o_result_high_byte,
  output logic [7:0]             o_result_low_byte,
  output logic                   o_conversion_busy_bit,
  output logic                   o_conversion_done_flag,
  output logic                   o_track,
  output logic                   o_convert
);
  sac_pkg::sac_state_e state_r;
  sac_pkg::sac_state_e state_nxt;
  logic [2:0]  pin_sync_r;
  logic [2:0]  lpo_sync_r;
  logic [4:0]  div_cnt_r;
  logic        sar_tick_r;
  logic [3:0]  ph_r;
  logic [6:0]  cnt_r;
  logic [15:0] acc_r;
  logic        busy_r;
  logic        start_evt;
  logic        pin_rise;
  logic        lpo_rise;
  logic        src_tick;
  logic        conv_end;
  logic        last;
  logic        lp_ext;
  logic [15:0] sum;

  // Repeat field to sample count
  function automatic logic [6:0] reps(input logic [2:0] sel);
    case (sel)
      sac_pkg::REP_4:  reps = 7'h04;
      sac_pkg::REP_8:  reps = 7'h08;
      sac_pkg::REP_16: reps = 7'h10;
      sac_pkg::REP_32: reps = 7'h20;
      sac_pkg::REP_64: reps = 7'h40;
      default:         reps = 7'h01;
    endcase
  endfunction

  // Selected start source, one cycle pulse
  function automatic logic pick_src(input sac_pkg::sac_cfg_s c, input sac_pkg::sac_tmr_s t,
                                    input logic sw, input logic rise);
    case (c.start_mode_select)
      sac_pkg::SM_SOFT: pick_src = sw;
      sac_pkg::SM_TMR0: pick_src = t.tmr0_ovf;
      sac_pkg::SM_TMR2: pick_src = t.tmr2_16bit ? t.tmr2_hi_ovf : t.tmr2_lo_ovf;
      sac_pkg::SM_TMR3: pick_src = t.tmr3_16bit ? t.tmr3_hi_ovf : t.tmr3_lo_ovf;
      sac_pkg::SM_EXT:  pick_src = rise;
      sac_pkg::SM_TMRX: pick_src = t.tmrx_ovf;
      default:          pick_src = 1'b0;
    endcase
  endfunction

  // Pin and oscillator pass two flops; third stage feeds edge detect
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_sync_r <= 3'h0;
      lpo_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], i_external_start_pin};
      lpo_sync_r <= {lpo_sync_r[1:0], i_lpo_clk};
    end
  end

  assign pin_rise  = pin_sync_r[1] & ~pin_sync_r[2];
  assign lpo_rise  = lpo_sync_r[1] & ~lpo_sync_r[2];
  assign start_evt = pick_src(i_cfg, i_tmr, i_sw_start, pin_rise);
  assign lp_ext    = i_cfg.tracking_mode_bit && (i_cfg.start_mode_select == sac_pkg::SM_EXT);

  // Conversion clock source: oscillator edges in burst, else every cycle
  assign src_tick = i_cfg.burst_enable_bit ? lpo_rise : 1'b1;

  // Conversion clock divider; tick is a one-cycle enable, not a clock
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt_r  <= 5'h00;
      sar_tick_r <= 1'b0;
    end else begin
      sar_tick_r <= 1'b0;
      if (src_tick) begin
        if (div_cnt_r >= i_cfg.conv_clock_divider) begin
          div_cnt_r  <= 5'h00;
          sar_tick_r <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 5'h01;
        end
      end
    end
  end

  assign conv_end = (state_r == sac_pkg::ST_CONV) && sar_tick_r &&
                    (ph_r == sac_pkg::CONV_CLKS - 4'h1);
  assign last     = (cnt_r + 7'h01) >= reps(i_cfg.repeat_count_select);

  // Sequencer next state; busy states ignore new starts
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sac_pkg::ST_IDLE: begin
        if (start_evt) begin
          // Pin-triggered low-power mode already tracked while pin was low
          if (i_cfg.tracking_mode_bit && !lp_ext) begin
            state_nxt = sac_pkg::ST_TRACK;
          end else begin
            state_nxt = sac_pkg::ST_CONV;
          end
        end
      end
      sac_pkg::ST_TRACK: begin
        if (sar_tick_r && ph_r == sac_pkg::TRACK_CLKS - 4'h1) begin
          state_nxt = sac_pkg::ST_CONV;
        end
      end
      sac_pkg::ST_CONV: begin
        if (conv_end) begin
          if (i_cfg.burst_enable_bit && !last) begin
            state_nxt = i_cfg.tracking_mode_bit ? sac_pkg::ST_TRACK : sac_pkg::ST_CONV;
          end else begin
            state_nxt = sac_pkg::ST_IDLE;
          end
        end
      end
      default: state_nxt = sac_pkg::ST_IDLE;
    endcase
  end

  // State and phase counter in conversion clocks
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= sac_pkg::ST_IDLE;
      ph_r    <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || conv_end) begin
        ph_r <= 4'h0;
      end else if (state_r != sac_pkg::ST_IDLE && sar_tick_r) begin
        ph_r <= ph_r + 4'h1;
      end
    end
  end

  // Busy high from start to conversion end; held through a burst series
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != sac_pkg::ST_IDLE);
    end
  end

  assign o_conversion_busy_bit = busy_r;

  // Accumulator: sums codes until the repeat count is reached
  assign sum = acc_r + {6'h00, i_sample_code};
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_r <= 16'h0000;
      cnt_r <= 7'h00;
    end else if (conv_end) begin
      if (last) begin
        acc_r <= 16'h0000;
        cnt_r <= 7'h00;
      end else begin
        acc_r <= sum;
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

  // Result bytes update only after the final conversion of a series
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_result_high_byte <= 8'h00;
      o_result_low_byte  <= 8'h00;
    end else if (conv_end && last) begin
      if (i_cfg.justify_shift_select == sac_pkg::JUST_LEFT) begin
        // Left layout meaningful for single samples only
        {o_result_high_byte, o_result_low_byte} <=
          {i_sample_code, {sac_pkg::LEFT_SHIFT{1'b0}}};
      end else begin
        // Right layout, zero fill above; optional shift of the sum
        {o_result_high_byte, o_result_low_byte} <=
          sum >> i_cfg.justify_shift_select[1:0];
      end
    end
  end

  // Done flag: set wins over a simultaneous software clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_conversion_done_flag <= 1'b0;
    end else if (conv_end && last) begin
      o_conversion_done_flag <= 1'b1;
    end else if (i_done_clear) begin
      o_conversion_done_flag <= 1'b0;
    end
  end

  // Track and convert controls to the analog front end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_track   <= 1'b0;
      o_convert <= 1'b0;
    end else begin
      o_convert <= (state_nxt == sac_pkg::ST_CONV);
      if (i_standby) begin
        o_track <= 1'b0;
      end else if (state_nxt == sac_pkg::ST_TRACK) begin
        o_track <= 1'b1;
      end else if (state_nxt == sac_pkg::ST_IDLE) begin
        o_track <= lp_ext ? ~pin_sync_r[1] :
                   (!i_cfg.tracking_mode_bit && !i_cfg.burst_enable_bit);
      end else begin
        o_track <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  start_busy_a: assert property (
    state_r == sac_pkg::ST_IDLE && start_evt |=> o_conversion_busy_bit)
    else $error("start did not raise busy");

  conv_busy_a: assert property (
    state_r != sac_pkg::ST_IDLE |-> o_conversion_busy_bit)
    else $error("busy low during conversion");

  done_fall_a: assert property (
    conv_end && last |=> !o_conversion_busy_bit && o_conversion_done_flag)
    else $error("done flag not set as busy fell");

  flag_hold_a: assert property (
    o_conversion_done_flag && !i_done_clear |=> o_conversion_done_flag)
    else $error("done flag dropped without clear");

  right_zero_a: assert property (
    conv_end && last && i_cfg.justify_shift_select == 3'h0 &&
    i_cfg.repeat_count_select == sac_pkg::REP_1 |=> o_result_high_byte[7:2] == 6'h00)
    else $error("unused high bits not zero");

  left_zero_a: assert property (
    conv_end && last && i_cfg.justify_shift_select == sac_pkg::JUST_LEFT
    |=> {o_result_high_byte, o_result_low_byte} == {$past(i_sample_code), 6'h00})
    else $error("left layout wrong");

  acc_sum_a: assert property (
    conv_end && !last |=> acc_r == $past(sum))
    else $error("accumulator did not add sample");

  track_len_a: assert property (
    state_r == sac_pkg::ST_TRACK && sar_tick_r && ph_r == sac_pkg::TRACK_CLKS - 4'h1
    |=> state_r == sac_pkg::ST_CONV)
    else $error("tracking not three clocks");

  ignore_a: assert property (
    state_r == sac_pkg::ST_CONV && start_evt && !sar_tick_r |=> $stable(ph_r) && $stable(cnt_r))
    else $error("start during conversion disturbed it");

  standby_a: assert property (
    i_standby |=> !o_track)
    else $error("tracking during standby");

  // Tracking follows the mode while idle and stops for conversion
  conv_track_a: assert property (
    state_nxt == sac_pkg::ST_CONV |=> o_convert && !o_track)
    else $error("tracking while converting");

  idle_track_a: assert property (
    state_nxt == sac_pkg::ST_IDLE && !i_standby && !i_cfg.tracking_mode_bit &&
    !i_cfg.burst_enable_bit |=> o_track)
    else $error("continuous tracking lost");

  pin_track_a: assert property (
    state_nxt == sac_pkg::ST_IDLE && lp_ext && pin_sync_r[1] |=> !o_track)
    else $error("tracking while start pin high");

  // Start source decode and conversion clock tick
  ext_start_a: assert property (
    state_r == sac_pkg::ST_IDLE && i_cfg.start_mode_select == sac_pkg::SM_EXT && pin_rise
    |=> o_conversion_busy_bit)
    else $error("pin rise did not start");

  tmr_width_a: assert property (
    state_r == sac_pkg::ST_IDLE && i_cfg.start_mode_select == sac_pkg::SM_TMR2 &&
    i_tmr.tmr2_16bit && !i_tmr.tmr2_hi_ovf |=> !o_conversion_busy_bit)
    else $error("wrong timer byte started a conversion");

  mode_none_a: assert property (
    state_r == sac_pkg::ST_IDLE && i_cfg.start_mode_select > sac_pkg::SM_TMRX
    |=> !o_conversion_busy_bit)
    else $error("unassigned start mode started");

  div_tick_a: assert property (
    sar_tick_r |-> $past(src_tick))
    else $error("conversion clock without source edge");

  // Series control and result register checks
  burst_busy_a: assert property (
    i_cfg.burst_enable_bit && conv_end && !last |=> o_conversion_busy_bit)
    else $error("burst series dropped busy");

  single_start_a: assert property (
    !i_cfg.burst_enable_bit && conv_end |=> !o_conversion_busy_bit)
    else $error("conversion ran on without a start");

  res_hold_a: assert property (
    !(conv_end && last) |=> $stable(o_result_high_byte) && $stable(o_result_low_byte))
    else $error("result changed inside a series");

  acc_clear_a: assert property (
    conv_end && last |=> acc_r == 16'h0000 && cnt_r == 7'h00)
    else $error("accumulator not cleared after series");

  done_clear_a: assert property (
    o_conversion_done_flag && i_done_clear && !(conv_end && last) |=> !o_conversion_done_flag)
    else $error("done flag ignored clear");

  cov_series_c: cover property (conv_end && last &&
                                i_cfg.repeat_count_select == sac_pkg::REP_64);
  cov_wide_c:   cover property (i_cfg.start_mode_select == sac_pkg::SM_TMR2 && i_tmr.tmr2_16bit &&
                                start_evt);
  cov_burst_c:  cover property (i_cfg.burst_enable_bit && conv_end && !last ##1 o_conversion_busy_bit);
  cov_ext_c:    cover property (lp_ext && pin_rise && state_r == sac_pkg::ST_IDLE);
  cov_left_c:   cover property (conv_end && i_cfg.justify_shift_select == sac_pkg::JUST_LEFT);
endmodule // sac_ctrl
`default_nettype wire
